// >>> pkg/io_cell_pkg.sv
// Constants shared by the configurable I/O cell: register map, field layout and mode codes.
package io_cell_pkg;

  // ****************************************************************
  // Register map.
  // ****************************************************************
  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 32;
  localparam logic [3:0]  ADDR_CONFIG     = 4'h0;
  localparam logic [3:0]  ADDR_STATUS     = 4'h4;
  localparam logic [31:0] CONFIG_RESET    = 32'h0000_0001;
  localparam logic [31:0] READ_ZERO       = 32'h0000_0000;

  // ****************************************************************
  // Configuration word layout.
  // ****************************************************************
  localparam int          IN_LSB          = 0;
  localparam int          IN_W            = 2;
  localparam int          OUT_LSB         = 2;
  localparam int          OUT_W           = 4;
  localparam int          POL_BIT         = 6;
  localparam int          VARIANT_BIT     = 7;
  localparam int          CFG_W           = 8;

  // ****************************************************************
  // Status word layout.
  // ****************************************************************
  localparam int          ST_RISE_BIT     = 0;
  localparam int          ST_FALL_BIT     = 1;
  localparam int          ST_PAD_IN_BIT   = 2;
  localparam int          ST_PAD_OUT_BIT  = 3;
  localparam int          ST_OE_N_BIT     = 4;

  // ****************************************************************
  // Input path codes.
  // ****************************************************************
  localparam logic [1:0]  IN_REGISTERED   = 2'h0;
  localparam logic [1:0]  IN_DIRECT       = 2'h1;
  localparam logic [1:0]  IN_LATCHED      = 2'h3;

  // ****************************************************************
  // Output path codes.
  // ****************************************************************
  localparam logic [3:0]  OUT_NONE        = 4'h0;
  localparam logic [3:0]  OUT_DDR         = 4'h4;
  localparam logic [3:0]  OUT_REG         = 4'h5;
  localparam logic [3:0]  OUT_DIRECT      = 4'h6;
  localparam logic [3:0]  OUT_REG_INV     = 4'h7;
  localparam logic [3:0]  OUT_DDR_TRI     = 4'h8;
  localparam logic [3:0]  OUT_REG_TRI     = 4'h9;
  localparam logic [3:0]  OUT_DIRECT_TRI  = 4'hA;
  localparam logic [3:0]  OUT_REG_TRI_INV = 4'hB;
  localparam logic [3:0]  OUT_DDR_TRI_REN = 4'hC;
  localparam logic [3:0]  OUT_REG_TRI_REN = 4'hD;
  localparam logic [3:0]  OUT_DIR_TRI_REN = 4'hE;
  localparam logic [3:0]  OUT_REG_REN_INV = 4'hF;

endpackage

// >>> logic/configurable_io_cell.sv
// Configurable I/O cell: selectable input and output paths between fabric and pad.
//
// Functional notes
// - Input code 01 passes the pad level straight to the fabric.
// - Input code 11 plain mode: latch follows pad, holds while hold is high.
// - Input code 00 registered: pad captured on input clock rising edge.
// - Input code 11 registered-latched: registered capture frozen while hold is high.
// - Input code 00 DDR: extra capture on falling edge to separate output.
// - Polarity option inverts both input capture and output launch clocks.
// - Output code 0000: no output, pad never driven.
// - Output code 0110: fabric data drives pad directly, always enabled.
// - Output code 1010: direct data through tristate with direct enable.
// - Output code 1110: tristate enable registered on launch clock.
// - Output code 0101: data registered on launch clock, always enabled.
// - Codes 1001 registered data, direct enable; 1101 both registered.
// - Output code 0100: rise value on rising edge, fall value on falling.
// - Codes 1000 DDR with direct enable; 1100 DDR with registered enable.
// - Output code 0111: registered output launched on inverted clock.
// - Codes 1011 and 1111: registered tristate variants on inverted clock.
//
// Chosen here: the placing of the registers and the address-and-strobe port.
module configurable_io_cell (
  input  wire logic                              clk_sys,
  input  wire logic                              resetn,
  input  wire logic [io_cell_pkg::ADDR_W-1:0]    bus_addr,
  input  wire logic [io_cell_pkg::DATA_W-1:0]    bus_wdata,
  input  wire logic                              bus_write,
  input  wire logic                              bus_read,
  output logic      [io_cell_pkg::DATA_W-1:0]    bus_rdata,
  input  wire logic                              input_capture_clock,
  input  wire logic                              output_launch_clock,
  input  wire logic                              input_hold,
  input  wire logic                              rise_launch_in,
  input  wire logic                              fall_launch_in,
  input  wire logic                              tristate_enable_in,
  input  wire logic                              pad_input_path,
  output logic                                   pad_output_path,
  output logic                                   pad_tristate_path_n,
  output logic                                   rise_capture_out,
  output logic                                   fall_capture_out
);

  // ****************************************************************
  // Helpers.
  // ****************************************************************

  // Edge test on a sampled clock level against its previous sample.
  function automatic logic edge_seen(input logic now_lvl, input logic old_lvl, input logic want_rise);
    edge_seen = want_rise ? (now_lvl & ~old_lvl) : (~now_lvl & old_lvl);
  endfunction

  // ****************************************************************
  // Register file.
  // ****************************************************************
  logic [io_cell_pkg::CFG_W-1:0]  cfg_reg;
  logic [io_cell_pkg::DATA_W-1:0] rdata_next;
  logic [io_cell_pkg::DATA_W-1:0] status_word;
  wire                            hit_config = (bus_addr == io_cell_pkg::ADDR_CONFIG);
  wire                            hit_status = (bus_addr == io_cell_pkg::ADDR_STATUS);

  wire [io_cell_pkg::IN_W-1:0]    in_code  = cfg_reg[io_cell_pkg::IN_LSB +: io_cell_pkg::IN_W];
  wire [io_cell_pkg::OUT_W-1:0]   out_code = cfg_reg[io_cell_pkg::OUT_LSB +: io_cell_pkg::OUT_W];
  wire                            pol_inv  = cfg_reg[io_cell_pkg::POL_BIT];
  wire                            variant  = cfg_reg[io_cell_pkg::VARIANT_BIT];

  // Status shows the cell's live path state; unused bits read zero.
  always_comb begin
    status_word                              = io_cell_pkg::READ_ZERO;
    status_word[io_cell_pkg::ST_RISE_BIT]    = rise_capture_out;
    status_word[io_cell_pkg::ST_FALL_BIT]    = fall_capture_out;
    status_word[io_cell_pkg::ST_PAD_IN_BIT]  = pad_input_path;
    status_word[io_cell_pkg::ST_PAD_OUT_BIT] = pad_output_path;
    status_word[io_cell_pkg::ST_OE_N_BIT]    = pad_tristate_path_n;
  end

  // Read data stand only in the cycle after the strobe; unmapped reads give zero.
  assign rdata_next = !bus_read ? io_cell_pkg::READ_ZERO :
                      hit_config ? {{(io_cell_pkg::DATA_W-io_cell_pkg::CFG_W){1'b0}}, cfg_reg} :
                      hit_status ? status_word : io_cell_pkg::READ_ZERO;

  // Configuration write and read answer.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cfg_reg   <= io_cell_pkg::CONFIG_RESET[io_cell_pkg::CFG_W-1:0];
      bus_rdata <= io_cell_pkg::READ_ZERO;
    end else begin
      if (bus_write && hit_config) begin
        cfg_reg <= bus_wdata[io_cell_pkg::CFG_W-1:0];
      end
      bus_rdata <= rdata_next;
    end
  end

  // ****************************************************************
  // Clock edge detection.
  // ****************************************************************
  // The pad clocks are sampled on clk_sys, so they must run well below 10 MHz.
  logic in_clk_prev_reg;
  logic out_clk_prev_reg;
  wire  in_clk_eff  = input_capture_clock ^ pol_inv;
  wire  out_clk_eff = output_launch_clock ^ pol_inv;
  wire  in_rise     = edge_seen(in_clk_eff, in_clk_prev_reg, 1'b1);
  wire  in_fall     = edge_seen(in_clk_eff, in_clk_prev_reg, 1'b0);
  wire  out_rise    = edge_seen(out_clk_eff, out_clk_prev_reg, 1'b1);
  wire  out_fall    = edge_seen(out_clk_eff, out_clk_prev_reg, 1'b0);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      in_clk_prev_reg  <= 1'b0;
      out_clk_prev_reg <= 1'b0;
    end else begin
      in_clk_prev_reg  <= in_clk_eff;
      out_clk_prev_reg <= out_clk_eff;
    end
  end

  // ****************************************************************
  // Input path.
  // ****************************************************************
  logic rise_next;
  logic fall_next;

  // Every mode lands in a flip-flop, so the direct path costs one clk_sys cycle.
  always_comb begin
    rise_next = rise_capture_out;
    fall_next = fall_capture_out;
    case (in_code)
      io_cell_pkg::IN_LATCHED: begin
        if (!variant) begin
          rise_next = input_hold ? rise_capture_out : pad_input_path;
        end else if (in_rise && !input_hold) begin
          rise_next = pad_input_path;
        end
      end
      io_cell_pkg::IN_REGISTERED: begin
        if (in_rise) begin
          rise_next = pad_input_path;
        end
        if (variant && in_fall) begin
          fall_next = pad_input_path;
        end
      end
      default: begin
        rise_next = pad_input_path;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rise_capture_out <= 1'b0;
      fall_capture_out <= 1'b0;
    end else begin
      rise_capture_out <= rise_next;
      fall_capture_out <= fall_next;
    end
  end

  // ****************************************************************
  // Output path.
  // ****************************************************************
  logic data_reg;
  logic ddr_reg;
  logic ten_reg;
  logic pad_out_next;
  logic oe_n_next;

  // inverted codes launch on the opposite edge
  wire  launch_inv = (out_code == io_cell_pkg::OUT_REG_INV) ||
                     (out_code == io_cell_pkg::OUT_REG_TRI_INV) ||
                     (out_code == io_cell_pkg::OUT_REG_REN_INV);
  wire  launch     = launch_inv ? out_fall : out_rise;

  // launch registers; DDR alternates rise and fall values
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      data_reg <= 1'b0;
      ddr_reg  <= 1'b0;
      ten_reg  <= 1'b0;
    end else begin
      if (launch) begin
        data_reg <= rise_launch_in;
        ten_reg  <= tristate_enable_in;
      end
      if (out_rise) begin
        ddr_reg <= rise_launch_in;
      end else if (out_fall) begin
        ddr_reg <= fall_launch_in;
      end
    end
  end

  // Pad data and active-low enable per output code.
  always_comb begin
    pad_out_next = 1'b0;
    oe_n_next    = 1'b1;
    case (out_code)
      io_cell_pkg::OUT_DIRECT: begin
        pad_out_next = rise_launch_in;
        oe_n_next    = 1'b0;
      end
      io_cell_pkg::OUT_DIRECT_TRI: begin
        pad_out_next = rise_launch_in;
        oe_n_next    = ~tristate_enable_in;
      end
      io_cell_pkg::OUT_DIR_TRI_REN: begin
        pad_out_next = rise_launch_in;
        oe_n_next    = ~ten_reg;
      end
      io_cell_pkg::OUT_REG, io_cell_pkg::OUT_REG_INV: begin
        pad_out_next = data_reg;
        oe_n_next    = 1'b0;
      end
      io_cell_pkg::OUT_REG_TRI, io_cell_pkg::OUT_REG_TRI_INV: begin
        pad_out_next = data_reg;
        oe_n_next    = ~tristate_enable_in;
      end
      io_cell_pkg::OUT_REG_TRI_REN, io_cell_pkg::OUT_REG_REN_INV: begin
        pad_out_next = data_reg;
        oe_n_next    = ~ten_reg;
      end
      io_cell_pkg::OUT_DDR: begin
        pad_out_next = ddr_reg;
        oe_n_next    = 1'b0;
      end
      io_cell_pkg::OUT_DDR_TRI: begin
        pad_out_next = ddr_reg;
        oe_n_next    = ~tristate_enable_in;
      end
      io_cell_pkg::OUT_DDR_TRI_REN: begin
        pad_out_next = ddr_reg;
        oe_n_next    = ~ten_reg;
      end
      default: begin
        pad_out_next = 1'b0;
        oe_n_next    = 1'b1;
      end
    endcase
  end

  // Pad pins leave from flip-flops so they cannot glitch on a code change.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pad_output_path     <= 1'b0;
      pad_tristate_path_n <= 1'b1;
    end else begin
      pad_output_path     <= pad_out_next;
      pad_tristate_path_n <= oe_n_next;
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  a_direct_input_path: assert property (@(posedge clk_sys) disable iff (!resetn)
    (in_code == io_cell_pkg::IN_DIRECT) |=> rise_capture_out == $past(pad_input_path))
    else $error("Direct input did not follow the pad.");

  a_latch_hold_freeze: assert property (@(posedge clk_sys) disable iff (!resetn)
    (in_code == io_cell_pkg::IN_LATCHED && !variant && input_hold) |=> $stable(rise_capture_out))
    else $error("Latched input moved while held.");

  a_reg_capture_edge: assert property (@(posedge clk_sys) disable iff (!resetn)
    (in_code == io_cell_pkg::IN_REGISTERED && in_rise) |=> rise_capture_out == $past(pad_input_path))
    else $error("Registered input missed a rising capture.");

  a_reg_hold_freeze: assert property (@(posedge clk_sys) disable iff (!resetn)
    (in_code == io_cell_pkg::IN_LATCHED && variant && (input_hold || !in_rise)) |=> $stable(rise_capture_out))
    else $error("Registered-latched input changed while frozen.");

  a_ddr_fall_capture: assert property (@(posedge clk_sys) disable iff (!resetn)
    (in_code == io_cell_pkg::IN_REGISTERED && variant && in_fall) |=> fall_capture_out == $past(pad_input_path))
    else $error("Falling capture missed.");

  a_no_output_drive: assert property (@(posedge clk_sys) disable iff (!resetn)
    (out_code == io_cell_pkg::OUT_NONE) |=> pad_tristate_path_n)
    else $error("Pad driven with no output function.");

  a_direct_output_on: assert property (@(posedge clk_sys) disable iff (!resetn)
    (out_code == io_cell_pkg::OUT_DIRECT) |=> !pad_tristate_path_n && pad_output_path == $past(rise_launch_in))
    else $error("Direct output wrong.");

  a_direct_tristate_en: assert property (@(posedge clk_sys) disable iff (!resetn)
    (out_code == io_cell_pkg::OUT_DIRECT_TRI) |=> pad_tristate_path_n == !$past(tristate_enable_in))
    else $error("Direct tristate enable wrong.");

  a_reg_launch_data: assert property (@(posedge clk_sys) disable iff (!resetn)
    (out_code == io_cell_pkg::OUT_REG && out_rise) ##1 (out_code == io_cell_pkg::OUT_REG && !launch)
      |=> pad_output_path == $past(rise_launch_in, 2))
    else $error("Registered output not launched on rising edge.");

  a_inv_launch_edge: assert property (@(posedge clk_sys) disable iff (!resetn)
    (out_code == io_cell_pkg::OUT_REG_INV && out_rise) |=> $stable(data_reg))
    else $error("Inverted output launched on the wrong edge.");

endmodule

// >>> bench/pad_board_model.sv
// Board-side model of the shared pad wire in front of the I/O cell.
module pad_board_model (
  input  wire logic pad_output_path,
  input  wire logic pad_tristate_path_n,
  input  wire logic board_drive_en,
  input  wire logic board_level,
  output logic      pad_wire
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Wire resolution.
  // ****************************************************************
  // The cell owns the wire while its active-low enable is low; otherwise the board drives it.
  // A released board leaves the pull-up in charge, so no stale level survives a release.
  assign pad_wire = !pad_tristate_path_n ? pad_output_path : (board_drive_en ? board_level : 1'b1);
endmodule

// >>> bench/testbench.sv
// Self-checking testbench for the configurable I/O cell and its board model.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Signals.
  // ****************************************************************
  logic        clk_sys;
  logic        resetn;
  logic [3:0]  bus_addr;
  logic [31:0] bus_wdata;
  logic        bus_write;
  logic        bus_read;
  logic [31:0] bus_rdata;
  logic        icc;
  logic        olc;
  logic        hold;
  logic        rli;
  logic        fli;
  logic        tei;
  logic        pad_wire;
  logic        pout;
  logic        poe_n;
  logic        rco;
  logic        fco;
  logic        bde;
  logic        blv;
  logic [31:0] rd;
  int          num_errors;
  int          checks;
  int          cycles;

  configurable_io_cell i_dut (
    .clk_sys(clk_sys), .resetn(resetn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata),
    .input_capture_clock(icc), .output_launch_clock(olc), .input_hold(hold),
    .rise_launch_in(rli), .fall_launch_in(fli), .tristate_enable_in(tei),
    .pad_input_path(pad_wire), .pad_output_path(pout), .pad_tristate_path_n(poe_n),
    .rise_capture_out(rco), .fall_capture_out(fco)
  );

  pad_board_model i_pad (
    .pad_output_path(pout), .pad_tristate_path_n(poe_n), .board_drive_en(bde),
    .board_level(blv), .pad_wire(pad_wire)
  );

  // Clock at 20 MHz.
  always #25 clk_sys = ~clk_sys;

  // Watchdog: the whole run needs well under this many cycles, so reaching it means a hang.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_test(input string n);
    $display("Test %s finished, mismatches so far %0d", n, num_errors);
  endtask

  // Four cycles cover every path latency, then look at the settled outputs mid-cycle.
  task automatic settle();
    repeat (4) @(negedge clk_sys);
  endtask

  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_wdata <= d;
    bus_write <= 1'b1;
    @(posedge clk_sys);
    bus_write <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so it is taken at that cycle's middle.
  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_read <= 1'b1;
    @(posedge clk_sys);
    bus_read <= 1'b0;
    @(negedge clk_sys);
    d = bus_rdata;
  endtask

  task automatic set_cfg(input logic [1:0] im, input logic [3:0] om, input logic pol, input logic vr);
    bus_wr(io_cell_pkg::ADDR_CONFIG, {24'h00_0000, vr, pol, om, im});
  endtask

  task automatic pad_to(input logic v, input logic h);
    @(posedge clk_sys);
    blv <= v;
    hold <= h;
    settle();
  endtask

  task automatic icc_to(input logic v);
    @(posedge clk_sys);
    icc <= v;
    settle();
  endtask

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_reset();
    bus_rd(io_cell_pkg::ADDR_CONFIG, rd);
    cmp_word(rd, 32'h0000_0001);
    cmp_bit(poe_n, 1'b1);
    bus_wr(io_cell_pkg::ADDR_CONFIG, 32'hFFFF_FF01);
    bus_wr(io_cell_pkg::ADDR_STATUS, 32'h0000_003D);
    bus_wr(4'h8, 32'h0000_003D);
    bus_rd(4'h8, rd);
    cmp_word(rd, 32'h0000_0000);
    bus_rd(io_cell_pkg::ADDR_CONFIG, rd);
    cmp_word(rd, 32'h0000_0001);
    end_test("reset");
  endtask

  // Hold is high throughout, so any latch left in the path would show.
  task automatic t_in_direct();
    logic [1:0] codes [2];
    codes[0] = io_cell_pkg::IN_DIRECT;
    codes[1] = 2'b10;
    for (int k = 0; k < 2; k++) begin
      set_cfg(codes[k], io_cell_pkg::OUT_NONE, 1'b0, 1'b0);
      pad_to(1'b1, 1'b1);
      cmp_bit(rco, 1'b1);
      pad_to(1'b0, 1'b1);
      cmp_bit(rco, 1'b0);
    end
    end_test("input direct");
  endtask

  task automatic t_in_latch();
    set_cfg(io_cell_pkg::IN_LATCHED, io_cell_pkg::OUT_NONE, 1'b0, 1'b0);
    pad_to(1'b1, 1'b0);
    cmp_bit(rco, 1'b1);
    pad_to(1'b0, 1'b1);
    cmp_bit(rco, 1'b1);
    pad_to(1'b0, 1'b0);
    cmp_bit(rco, 1'b0);
    end_test("input latch");
  endtask

  // With polarity set, the pin's falling edge is the capture edge.
  task automatic t_in_reg(input logic pol);
    set_cfg(io_cell_pkg::IN_REGISTERED, io_cell_pkg::OUT_NONE, pol, 1'b0);
    pad_to(1'b0, 1'b0);
    icc_to(1'b1);
    icc_to(1'b0);
    pad_to(1'b1, 1'b0);
    cmp_bit(rco, 1'b0);
    icc_to(1'b1);
    cmp_bit(rco, !pol);
    icc_to(1'b0);
    cmp_bit(rco, 1'b1);
    end_test("input registered");
  endtask

  task automatic t_in_reglatch();
    set_cfg(io_cell_pkg::IN_LATCHED, io_cell_pkg::OUT_NONE, 1'b0, 1'b1);
    pad_to(1'b1, 1'b0);
    icc_to(1'b1);
    icc_to(1'b0);
    pad_to(1'b0, 1'b1);
    icc_to(1'b1);
    cmp_bit(rco, 1'b1);
    pad_to(1'b0, 1'b0);
    icc_to(1'b0);
    icc_to(1'b1);
    cmp_bit(rco, 1'b0);
    icc_to(1'b0);
    end_test("input registered latch");
  endtask

  task automatic t_in_ddr();
    set_cfg(io_cell_pkg::IN_REGISTERED, io_cell_pkg::OUT_NONE, 1'b0, 1'b1);
    for (int v = 0; v < 2; v++) begin
      pad_to(v[0], 1'b0);
      icc_to(1'b1);
      pad_to(!v[0], 1'b0);
      icc_to(1'b0);
      cmp_bit(rco, v[0]);
      cmp_bit(fco, !v[0]);
    end
    bus_rd(io_cell_pkg::ADDR_STATUS, rd);
    cmp_word(rd & 32'h0000_0007, 32'h0000_0001);
    end_test("input ddr");
  endtask

  // Every output code, launched by one pin rise and one pin fall after quiet inputs.
  // Code bits 3:2 pick the enable kind and bits 1:0 the data kind, so expectations are derived per field.
  task automatic t_out(input logic pol);
    logic [3:0] c;
    int         r;
    int         ls;
    logic       en_on;
    logic       d_on;
    r = pol ? 4 : 3;
    for (int k = 0; k < 16; k++) begin
      c = k[3:0];
      ls = (c[1:0] == 2'b11) ? 7 - r : r;
      @(posedge clk_sys);
      rli <= 1'b0;
      fli <= 1'b0;
      tei <= 1'b0;
      set_cfg(io_cell_pkg::IN_DIRECT, c, pol, 1'b0);
      // Both pin edges pass with quiet inputs first, so every launch register starts at zero
      // whatever the code or polarity; data and enable then rise with no clock edge beside them.
      @(posedge clk_sys);
      olc <= 1'b1;
      settle();
      @(posedge clk_sys);
      olc <= 1'b0;
      settle();
      @(posedge clk_sys);
      rli <= 1'b1;
      tei <= 1'b1;
      for (int s = 2; s <= 4; s++) begin
        if (s > 2) begin
          @(posedge clk_sys);
          olc <= (s == 3);
        end
        settle();
        en_on = (c[3:2] != 2'b00) && (c[3:2] != 2'b11 || s >= ls);
        d_on = (c[1:0] == 2'b10) ? 1'b1 : ((c[1:0] == 2'b00) ? (s == r) : (s >= ls));
        cmp_bit(poe_n, !en_on);
        if (en_on) begin
          cmp_bit(pad_wire, d_on);
        end
      end
    end
    end_test("output codes");
  endtask

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    clk_sys = 1'b0;
    resetn = 1'b0;
    bus_addr = 4'h0;
    bus_wdata = 32'h0000_0000;
    bus_write = 1'b0;
    bus_read = 1'b0;
    icc = 1'b0;
    olc = 1'b0;
    hold = 1'b0;
    rli = 1'b0;
    fli = 1'b0;
    tei = 1'b0;
    bde = 1'b1;
    blv = 1'b0;
    num_errors = 0;
    checks = 0;
    cycles = 0;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reset();
    t_in_direct();
    t_in_latch();
    t_in_reg(1'b0);
    t_in_reg(1'b1);
    t_in_reglatch();
    t_in_ddr();
    @(posedge clk_sys);
    bde <= 1'b0;
    t_out(1'b0);
    t_out(1'b1);
    final_report();
  end
endmodule
